// [src/compare_stage.sv]
// one programmable compare stage: comparison, hysteresis, floor and definite-time delay
module compare_stage (
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  input  wire logic                                  ce,
  input  wire logic                                  eval_tick,
  input  wire logic                                  ms_tick,
  input  wire logic                                  enable,
  input  wire logic                                  sel_ok,
  input  wire logic [1:0]                            mode,
  input  wire logic signed [prog_stage_pkg::SIG_W-1:0] sig_a,
  input  wire logic signed [prog_stage_pkg::SIG_W-1:0] sig_b,
  input  wire logic signed [prog_stage_pkg::SIG_W-1:0] start_thr,
  input  wire logic signed [prog_stage_pkg::SIG_W-1:0] hyst,
  input  wire logic signed [prog_stage_pkg::SIG_W-1:0] under_mode_compare_floor,
  input  wire logic [prog_stage_pkg::DELAY_W-1:0]    delay_ms,
  output logic                                       start,
  output logic                                       trip
);
  import prog_stage_pkg::*;

  localparam int XW = SIG_W + 2;

  logic signed [XW-1:0] a, b, thr, hy, flr, d, ad;
  logic                 on_cond, off_cond;
  logic [DELAY_W-1:0]   elapsed;
  logic                 start_drop;

  assign a   = XW'(sig_a);
  assign b   = XW'(sig_b);
  assign thr = XW'(start_thr);
  assign hy  = XW'(hyst);
  assign flr = XW'(under_mode_compare_floor);
  assign d   = a - b;
  assign ad  = d[XW-1] ? -d : d;

  // trip falls on the same edge as start, so it never outlives start by a cycle
  assign start_drop = !enable || !sel_ok || (eval_tick && start && off_cond);

  always_comb begin
    on_cond  = 1'b0;
    off_cond = 1'b1;
    case (mode)
      MODE_OVER: begin
        on_cond  = a > thr;
        off_cond = a < thr - hy;
      end
      MODE_UNDER: begin
        // below the floor is a dead measurement, not an under-value fault
        on_cond  = a < thr && a >= flr;
        off_cond = a > thr + hy || a < flr;
      end
      MODE_DIFF: begin
        on_cond  = d > 0 && d > thr;
        off_cond = d <= 0 || d < thr - hy;
      end
      MODE_ABS: begin
        on_cond  = ad > thr;
        off_cond = ad < thr - hy;
      end
      default: begin
        on_cond  = 1'b0;
        off_cond = 1'b1;
      end
    endcase
  end

  // the comparison only moves on the evaluation tick of the chosen period
  always_ff @(posedge clk) begin
    if (rst) begin
      start <= 1'b0;
    end else if (ce) begin
      if (!enable || !sel_ok)
        start <= 1'b0;
      else if (eval_tick && !start && on_cond)
        start <= 1'b1;
      else if (eval_tick && start && off_cond)
        start <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      elapsed <= '0;
      trip    <= 1'b0;
    end else if (ce) begin
      if (!start || start_drop) begin
        elapsed <= '0;
        trip    <= 1'b0;
      end else if (!trip) begin
        if (elapsed >= delay_ms)
          trip <= 1'b1;
        else if (ms_tick)
          elapsed <= elapsed + DELAY_W'(1);
      end
    end
  end
endmodule

// [src/eval_tick_gen.sv]
// millisecond tick and the three evaluation period ticks
module eval_tick_gen #(
  parameter int MS_CYCLES = prog_stage_pkg::MS_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  output logic            ms_tick,
  output logic [2:0]      period_tick
);
  import prog_stage_pkg::*;

  logic [31:0] cyc_cnt;
  logic [6:0]  ms_cnt [3];

  localparam logic [6:0] PERIOD_MS [3] = '{7'(PERIOD_10_MS), 7'(PERIOD_20_MS), 7'(PERIOD_100_MS)};

  always_ff @(posedge clk) begin
    if (rst) begin
      cyc_cnt <= '0;
      ms_tick <= 1'b0;
    end else if (ce) begin
      ms_tick <= (cyc_cnt == 32'(MS_CYCLES - 1));
      cyc_cnt <= (cyc_cnt == 32'(MS_CYCLES - 1)) ? '0 : cyc_cnt + 32'h1;
    end
  end

  for (genvar p = 0; p < 3; p++) begin : g_period
    always_ff @(posedge clk) begin
      if (rst) begin
        ms_cnt[p]      <= '0;
        period_tick[p] <= 1'b0;
      end else if (ce) begin
        period_tick[p] <= 1'b0;
        if (ms_tick) begin
          if (ms_cnt[p] == PERIOD_MS[p] - 7'h1) begin
            ms_cnt[p]      <= '0;
            period_tick[p] <= 1'b1;
          end else begin
            ms_cnt[p] <= ms_cnt[p] + 7'h1;
          end
        end
      end
    end
  end
endmodule

// [src/prog_compare_bank.sv]
// eight programmable compare stages with Avalon-MM settings and interrupt
module prog_compare_bank
  import prog_stage_pkg::*;
#(
  parameter int MS_CYCLES = prog_stage_pkg::MS_CYCLES
) (
  input  wire logic                                          clk,
  input  wire logic                                          rst,
  input  wire logic                                          ce,
  input  wire logic [prog_stage_pkg::ADDR_W-1:0]             address,
  input  wire logic                                          read,
  input  wire logic                                          write,
  input  wire logic [31:0]                                   writedata,
  input  wire logic [3:0]                                    byteenable,
  output logic [31:0]                                        readdata,
  output logic                                               waitrequest,
  input  wire logic [prog_stage_pkg::NUM_SIGNALS*prog_stage_pkg::SIG_W-1:0] sig_values,
  input  wire logic                                          option_module_fitted,
  output logic [prog_stage_pkg::NUM_STAGES-1:0]              stage_start,
  output logic [prog_stage_pkg::NUM_STAGES-1:0]              stage_trip,
  output logic                                               irq
);
  import prog_stage_pkg::*;

  logic [31:0]             setting [NUM_GROUPS][NUM_STAGES][NUM_FIELDS];
  logic [1:0]              active_group;
  logic [2*NUM_STAGES-1:0] irq_status;
  logic [2*NUM_STAGES-1:0] irq_mask;
  logic [NUM_STAGES-1:0]   sel_fault;
  logic [CNT_W-1:0]        trip_count [NUM_STAGES];
  logic [NUM_STAGES-1:0]   start_q;
  logic [NUM_STAGES-1:0]   trip_q;
  logic                    opt_meta;
  logic                    opt_sync;
  logic                    ack;
  logic                    wr_take;
  logic                    rd_load;
  logic [31:0]             rd_word;
  logic [31:0]             wr_word;
  logic                    in_window;
  logic [1:0]              win_group;
  logic [2:0]              win_stage;
  logic [2:0]              win_field;
  logic                    ms_tick;
  logic [2:0]              period_tick;

  // single wait state: data is prepared one cycle after the request appears
  assign waitrequest = (read | write) & ~ack;
  assign wr_take     = write & ack;
  assign rd_load     = read & ~ack;

  assign in_window = address[ADDR_W-1:ADDR_W-2] == STAGE_WIN && address[4:2] < 3'(NUM_FIELDS);
  assign win_group = address[9:8];
  assign win_stage = address[7:5];
  assign win_field = address[4:2];

  always_ff @(posedge clk) begin
    if (rst)
      ack <= 1'b0;
    else if (ce)
      ack <= (read | write) & ~ack;
  end

  // presence of the expansion module arrives from outside this clock domain
  always_ff @(posedge clk) begin
    if (rst) begin
      opt_meta <= 1'b0;
      opt_sync <= 1'b0;
    end else if (ce) begin
      opt_meta <= option_module_fitted;
      opt_sync <= opt_meta;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  function automatic logic sel_usable(input logic [SEL_W-1:0] sel, input logic fitted);
    logic ok;
    ok = sel < 6'(NUM_SIGNALS);
    if (sel >= SIG_OPT_FIRST && sel <= SIG_OPT_LAST && !fitted)
      ok = 1'b0;
    return ok;
  endfunction

  always_comb begin
    wr_word = merge(setting[win_group][win_stage][win_field], writedata, byteenable);
    if (win_field == FIELD_START &&
        $signed(wr_word) > $signed(start_limit(setting[win_group][win_stage][FIELD_CFG][CFG_SELA_LSB +: SEL_W])))
      wr_word = start_limit(setting[win_group][win_stage][FIELD_CFG][CFG_SELA_LSB +: SEL_W]);
  end

  // settings live in four banks; software may edit any bank while another runs
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int g = 0; g < NUM_GROUPS; g++)
        for (int s = 0; s < NUM_STAGES; s++)
          for (int f = 0; f < NUM_FIELDS; f++)
            setting[g][s][f] <= RESET_WORD;
    end else if (ce && wr_take && in_window) begin
      setting[win_group][win_stage][win_field] <= wr_word;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      active_group <= '0;
      irq_mask     <= '0;
    end else if (ce && wr_take) begin
      if (address == ADDR_CTRL && byteenable[0])
        active_group <= writedata[CTRL_GROUP_LSB +: 2];
      if (address == ADDR_IRQ_MASK)
        irq_mask <= (2*NUM_STAGES)'(merge(32'(irq_mask), writedata, byteenable));
    end
  end

  // a new edge in the clearing cycle survives the write-one-to-clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status <= '0;
      start_q    <= '0;
      trip_q     <= '0;
    end else if (ce) begin
      start_q    <= stage_start;
      trip_q     <= stage_trip;
      irq_status <= (irq_status & ~((wr_take && address == ADDR_IRQ_STATUS) ?
                                    writedata[2*NUM_STAGES-1:0] : '0))
                    | {stage_trip & ~trip_q, stage_start & ~start_q};
    end
  end

  assign irq = |(irq_status & irq_mask);

  for (genvar i = 0; i < NUM_STAGES; i++) begin : g_stage
    logic [31:0]      cfg;
    logic [1:0]       mode;
    logic [1:0]       period;
    logic [SEL_W-1:0] sel_a;
    logic [SEL_W-1:0] sel_b;
    logic             two_sig;
    logic             ok;
    logic             tick;
    logic [SIG_W-1:0] val_a;
    logic [SIG_W-1:0] val_b;

    assign cfg     = setting[active_group][i][FIELD_CFG];
    assign mode    = cfg[CFG_MODE_LSB +: 2];
    assign period  = cfg[CFG_PERIOD_LSB +: 2];
    assign sel_a   = cfg[CFG_SELA_LSB +: SEL_W];
    assign sel_b   = cfg[CFG_SELB_LSB +: SEL_W];
    assign two_sig = mode == MODE_DIFF || mode == MODE_ABS;
    // the second choice is only checked and read when a difference mode needs it
    assign ok      = sel_usable(sel_a, opt_sync) && (!two_sig || sel_usable(sel_b, opt_sync));
    assign val_a   = sel_a < 6'(NUM_SIGNALS) ? sig_values[32'(sel_a)*SIG_W +: SIG_W] : '0;
    assign val_b   = two_sig && sel_b < 6'(NUM_SIGNALS) ? sig_values[32'(sel_b)*SIG_W +: SIG_W] : '0;
    // software is trusted to match the period to the needed operate time
    assign tick    = period == PERIOD_SEL_10 ? period_tick[0] :
                     period == PERIOD_SEL_20 ? period_tick[1] : period_tick[2];

    compare_stage u_stage (
      .clk                      (clk),
      .rst                      (rst),
      .ce                       (ce),
      .eval_tick                (tick),
      .ms_tick                  (ms_tick),
      .enable                   (cfg[CFG_EN_BIT]),
      .sel_ok                   (ok),
      .mode                     (mode),
      .sig_a                    (val_a),
      .sig_b                    (val_b),
      .start_thr                (setting[active_group][i][FIELD_START]),
      .hyst                     (setting[active_group][i][FIELD_HYST]),
      .under_mode_compare_floor (setting[active_group][i][FIELD_FLOOR]),
      .delay_ms                 (setting[active_group][i][FIELD_DELAY][DELAY_W-1:0]),
      .start                    (stage_start[i]),
      .trip                     (stage_trip[i])
    );

    always_ff @(posedge clk) begin
      if (rst) begin
        sel_fault[i]  <= 1'b0;
        trip_count[i] <= '0;
      end else if (ce) begin
        sel_fault[i] <= cfg[CFG_EN_BIT] && !ok;
        if (wr_take && address == ADDR_TRIP_CNT + 12'(4*i))
          trip_count[i] <= '0;
        else if (stage_trip[i] && !trip_q[i] && trip_count[i] != '1)
          trip_count[i] <= trip_count[i] + CNT_W'(1);
      end
    end
  end

  eval_tick_gen #(
    .MS_CYCLES (MS_CYCLES)
  ) u_ticks (
    .clk         (clk),
    .rst         (rst),
    .ce          (ce),
    .ms_tick     (ms_tick),
    .period_tick (period_tick)
  );

  always_comb begin
    rd_word = '0;
    if (in_window)
      rd_word = setting[win_group][win_stage][win_field];
    else if (address >= ADDR_TRIP_CNT && address < ADDR_TRIP_CNT + 12'(4*NUM_STAGES) && address[1:0] == 2'h0)
      rd_word = 32'(trip_count[address[4:2]]);
    else begin
      case (address)
        ADDR_CTRL:       rd_word = 32'(active_group);
        ADDR_START_STAT: rd_word = 32'(stage_start);
        ADDR_TRIP_STAT:  rd_word = 32'(stage_trip);
        ADDR_IRQ_STATUS: rd_word = 32'(irq_status);
        ADDR_IRQ_MASK:   rd_word = 32'(irq_mask);
        ADDR_SEL_FAULT:  rd_word = 32'(sel_fault);
        ADDR_OPTION:     rd_word = 32'(opt_sync);
        default:         rd_word = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      readdata <= '0;
    else if (ce && rd_load)
      readdata <= rd_word;
  end
endmodule

// [src/prog_stage_pkg.sv]
// constants, register map and signal catalogue for the programmable compare stages
package prog_stage_pkg;

  localparam int NUM_STAGES  = 8;
  localparam int NUM_GROUPS  = 4;
  localparam int NUM_FIELDS  = 5;
  localparam int NUM_SIGNALS = 49;
  localparam int SIG_W       = 32;
  localparam int SEL_W       = 6;
  localparam int DELAY_W     = 16;
  localparam int ADDR_W      = 12;
  localparam int CNT_W       = 16;

  // timing: one millisecond tick derived from the 40 MHz clock
  localparam int CLK_HZ       = 40_000_000;
  localparam int MS_TICK_US   = 1000;
  localparam int MS_CYCLES    = CLK_HZ / 1_000_000 * MS_TICK_US;
  localparam int PERIOD_10_MS  = 10;
  localparam int PERIOD_20_MS  = 20;
  localparam int PERIOD_100_MS = 100;

  // comparison modes
  localparam logic [1:0] MODE_OVER  = 2'h0;
  localparam logic [1:0] MODE_UNDER = 2'h1;
  localparam logic [1:0] MODE_DIFF  = 2'h2;
  localparam logic [1:0] MODE_ABS   = 2'h3;  // magnitude_difference_mode

  // evaluation period codes
  localparam logic [1:0] PERIOD_SEL_10  = 2'h0;
  localparam logic [1:0] PERIOD_SEL_20  = 2'h1;
  localparam logic [1:0] PERIOD_SEL_100 = 2'h2;

  // global registers (byte addresses)
  localparam logic [ADDR_W-1:0] ADDR_CTRL       = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_START_STAT = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_TRIP_STAT  = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_SEL_FAULT  = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_OPTION     = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_TRIP_CNT   = 12'h040;  // + stage*4
  // stage settings window: 0x400 + group*0x100 + stage*0x20 + field*4
  localparam logic [1:0]        STAGE_WIN       = 2'h1;

  localparam logic [2:0] FIELD_CFG   = 3'h0;
  localparam logic [2:0] FIELD_START = 3'h1;
  localparam logic [2:0] FIELD_HYST  = 3'h2;
  localparam logic [2:0] FIELD_FLOOR = 3'h3;
  localparam logic [2:0] FIELD_DELAY = 3'h4;

  // configuration word layout
  localparam int CFG_EN_BIT     = 0;
  localparam int CFG_MODE_LSB   = 1;
  localparam int CFG_PERIOD_LSB = 3;
  localparam int CFG_SELA_LSB   = 8;
  localparam int CFG_SELB_LSB   = 16;
  localparam int CTRL_GROUP_LSB = 0;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // signal catalogue indices
  localparam logic [SEL_W-1:0] SIG_FREQ      = 6'h0b;
  localparam logic [SEL_W-1:0] SIG_COSPHI    = 6'h0f;
  localparam logic [SEL_W-1:0] SIG_I2_I1     = 6'h13;
  localparam logic [SEL_W-1:0] SIG_U2_U1     = 6'h17;
  localparam logic [SEL_W-1:0] SIG_TANPHI    = 6'h19;
  localparam logic [SEL_W-1:0] SIG_OPT_FIRST = 6'h1d;  // harmonic and breaker-side frequencies
  localparam logic [SEL_W-1:0] SIG_THD_LAST  = 6'h22;
  localparam logic [SEL_W-1:0] SIG_OPT_LAST  = 6'h24;
  localparam logic [SEL_W-1:0] SIG_VAI_FIRST = 6'h2c;  // five network_virtual_analog_input values
  localparam logic [SEL_W-1:0] SIG_VAI_LAST  = 6'h30;

  // start threshold ceilings by signal class
  localparam logic [31:0] START_MAX_FREQ  = 32'h0001_3880;
  localparam logic [31:0] START_MAX_RATIO = 32'h0000_2710;
  localparam logic [31:0] START_MAX_ANY   = 32'h7fff_ffff;

  function automatic logic [31:0] start_limit(input logic [SEL_W-1:0] sel);
    logic [31:0] lim;
    lim = START_MAX_ANY;
    if (sel == SIG_FREQ || sel > SIG_THD_LAST && sel <= SIG_OPT_LAST)
      lim = START_MAX_FREQ;
    else if (sel == SIG_COSPHI || sel == SIG_I2_I1 || sel == SIG_U2_U1 || sel == SIG_TANPHI ||
             (sel >= SIG_OPT_FIRST && sel <= SIG_THD_LAST))
      lim = START_MAX_RATIO;
    return lim;
  endfunction

endpackage

// [test/prog_compare_bank_assertions.sv]
// port-level assertions for the programmable compare bank
module prog_compare_bank_checker
  import prog_stage_pkg::*;
#(
  parameter int MS_CYCLES = prog_stage_pkg::MS_CYCLES
) (
  input  wire logic                                                         clk,
  input  wire logic                                                         rst,
  input  wire logic                                                         ce,
  input  wire logic [prog_stage_pkg::ADDR_W-1:0]                            address,
  input  wire logic                                                         read,
  input  wire logic                                                         write,
  input  wire logic [31:0]                                                  writedata,
  input  wire logic [3:0]                                                   byteenable,
  input  wire logic [31:0]                                                  readdata,
  input  wire logic                                                         waitrequest,
  input  wire logic [prog_stage_pkg::NUM_SIGNALS*prog_stage_pkg::SIG_W-1:0] sig_values,
  input  wire logic                                                         option_module_fitted,
  input  wire logic [prog_stage_pkg::NUM_STAGES-1:0]                        stage_start,
  input  wire logic [prog_stage_pkg::NUM_STAGES-1:0]                        stage_trip,
  input  wire logic                                                         irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_wait_first: assert property ((read || write) && !$past(read || write) && ce |-> waitrequest)
    else $error("request not stalled in its first cycle");
  a_wait_single: assert property ((read || write) && waitrequest && ce |=> !waitrequest)
    else $error("more than one wait state");
  a_idle_free: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest without a request");
  a_rdata_hold: assert property (!$past(read && waitrequest && ce) |-> $stable(readdata))
    else $error("readdata moved outside a read");
  a_trip_in_start: assert property ((stage_trip & ~stage_start) == '0)
    else $error("trip without start");
  a_trip_late: assert property ((stage_trip & ~$past(stage_trip) & ~(stage_start & $past(stage_start))) == '0)
    else $error("trip rose too soon after start");
  // reset is checked with the default disable switched off
  a_reset_quiet: assert property (disable iff (1'b0) rst && ce |=> stage_start == '0 && stage_trip == '0 && !irq)
    else $error("outputs active after reset");
  a_irq_drop: assert property ($fell(irq) |-> $past(write && !waitrequest && ce))
    else $error("irq fell without a register write");
endmodule

bind prog_compare_bank prog_compare_bank_checker #(.MS_CYCLES(MS_CYCLES)) chk (
  .clk(clk), .rst(rst), .ce(ce), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .sig_values(sig_values), .option_module_fitted(option_module_fitted),
  .stage_start(stage_start), .stage_trip(stage_trip), .irq(irq)
);

// [test/tb_prog_compare_bank.sv]
// self-checking bench for the programmable compare bank
module tb_prog_compare_bank
  import prog_stage_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC  = 4;
  localparam int EVAL = 3 * PERIOD_10_MS * MSC;
  logic                             clk, rst, ce, read, write, option_module_fitted, irq, waitrequest;
  logic [ADDR_W-1:0]                address;
  logic [31:0]                      writedata, readdata, q;
  logic [3:0]                       byteenable;
  logic [NUM_SIGNALS*SIG_W-1:0]     sig_values;
  logic [NUM_STAGES-1:0]            stage_start, stage_trip;
  int                               mismatches, check_count, n;
  // mode table: over, disabled, over low, under, under below floor, diff neg, diff pos, abs, abs small
  logic [1:0] tm [9] = '{MODE_OVER, MODE_OVER, MODE_OVER, MODE_UNDER, MODE_UNDER, MODE_DIFF, MODE_DIFF, MODE_ABS, MODE_ABS};
  logic       te [9] = '{1, 0, 1, 1, 1, 1, 1, 1, 1};
  logic       tx [9] = '{1, 0, 0, 1, 0, 0, 1, 1, 0};
  int         ta [9] = '{150, 150, 50, 50, 10, 50, 250, 50, 150};
  int         tbv [9] = '{0, 0, 0, 0, 0, 200, 100, 200, 100};

  prog_compare_bank #(.MS_CYCLES(MSC)) dut (
    .clk(clk), .rst(rst), .ce(ce), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .sig_values(sig_values), .option_module_fitted(option_module_fitted),
    .stage_start(stage_start), .stage_trip(stage_trip), .irq(irq)
  );

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one Avalon transfer; holds everything until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 0;
    write <= 0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus(1, a, d);
  endtask

  task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string nm);
    bus(0, a, 32'h0);
    check(nm, q, exp);
  endtask

  function automatic logic [ADDR_W-1:0] sa(input int g, input int s, input int f);
    return ADDR_W'(32'h400 + g * 256 + s * 32 + f * 4);
  endfunction

  function automatic logic [31:0] cfgw(input logic en, input logic [1:0] m, input int sa_, input int sb);
    return 32'(en) | (32'(m) << CFG_MODE_LSB) | (32'(sa_) << CFG_SELA_LSB) | (32'(sb) << CFG_SELB_LSB);
  endfunction

  task automatic setsig(input int k, input int v);
    sig_values[k*SIG_W +: SIG_W] <= v;
  endtask

  // evaluation follows the 10 ms period tick, so three periods always cover it
  task automatic settle();
    repeat (EVAL) @(posedge clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    results();
  end

  initial begin
    {rst, ce, read, write, option_module_fitted} = 5'b11000;
    address = '0;
    writedata = '0;
    byteenable = 4'hf;
    sig_values = '0;
    repeat (20) @(posedge clk);
    rst <= 0;
    rc(ADDR_CTRL, 32'h0, "ctrl reset");
    rc(ADDR_START_STAT, 32'h0, "start reset");
    rc(ADDR_IRQ_STATUS, 32'h0, "irq status reset");
    rc(12'h020, 32'h0, "unmapped read");
    rc(sa(0, 0, 5), 32'h0, "unmapped field");
    $display("test reset done");
    // over mode with delay, interrupt masked then unmasked, hysteresis release
    setsig(0, 150);
    wr(sa(0, 0, 1), 100);
    wr(sa(0, 0, 2), 10);
    wr(sa(0, 0, 4), 2);
    wr(sa(0, 0, 0), cfgw(1, MODE_OVER, 0, 0));
    n = 0;
    while (stage_start[0] !== 1'b1 && n < EVAL) begin
      @(posedge clk);
      n++;
    end
    check("start0", 32'(stage_start[0]), 1);
    check("trip0 early", 32'(stage_trip[0]), 0);
    n = 0;
    while (stage_trip[0] !== 1'b1 && n < EVAL) begin
      @(posedge clk);
      n++;
    end
    check("trip0 delay", 32'(n >= MSC && n < EVAL), 1);
    rc(ADDR_TRIP_STAT, 32'h1, "trip stat");
    rc(ADDR_IRQ_STATUS, 32'h101, "irq status");
    check("irq masked", 32'(irq), 0);
    wr(ADDR_IRQ_MASK, 32'h0000ffff);
    @(posedge clk);
    check("irq on", 32'(irq), 1);
    wr(ADDR_IRQ_STATUS, 32'h101);
    rc(ADDR_IRQ_STATUS, 32'h0, "irq cleared");
    check("irq off", 32'(irq), 0);
    setsig(0, 95);
    settle();
    check("inside band", 32'(stage_start[0]), 1);
    setsig(0, 85);
    settle();
    check("below band", 32'({stage_trip[0], stage_start[0]}), 0);
    rc(ADDR_TRIP_CNT, 32'h1, "trip count");
    wr(ADDR_TRIP_CNT, 32'h0);
    rc(ADDR_TRIP_CNT, 32'h0, "trip count clear");
    $display("test over mode done");
    // every mode; sel_b invalid (63) outside the difference modes must be ignored
    wr(sa(0, 1, 1), 100);
    wr(sa(0, 1, 3), 20);
    for (int i = 0; i < 9; i++) begin
      wr(sa(0, 1, 0), 32'h0);
      setsig(1, ta[i]);
      setsig(2, tbv[i]);
      wr(sa(0, 1, 0), cfgw(te[i], tm[i], 1, tm[i] >= MODE_DIFF ? 2 : 63));
      settle();
      check($sformatf("mode case %0d", i), 32'(stage_start[1]), 32'(tx[i]));
    end
    $display("test modes done");
    // group 1 only: stage 2 on signal 3, stage 5 on the last network input
    setsig(3, 500);
    setsig(48, 500);
    wr(sa(1, 2, 1), 100);
    wr(sa(1, 2, 0), cfgw(1, MODE_OVER, 3, 0));
    wr(sa(1, 5, 1), 100);
    wr(sa(1, 5, 0), cfgw(1, MODE_OVER, 48, 0));
    settle();
    check("group0 idle", 32'(stage_start[2]), 0);
    wr(ADDR_CTRL, 32'h1);
    settle();
    check("group1 stage", 32'(stage_start[2]), 1);
    check("network input", 32'(stage_start[5]), 1);
    rc(ADDR_CTRL, 32'h1, "ctrl group");
    $display("test groups done");
    // threshold ceiling and optional-module signals
    wr(sa(1, 4, 0), cfgw(0, MODE_OVER, SIG_FREQ, 0));
    wr(sa(1, 4, 1), 32'h7fff0000);
    rc(sa(1, 4, 1), START_MAX_FREQ, "start clamp");
    wr(sa(1, 4, 0), cfgw(1, MODE_OVER, SIG_OPT_FIRST, 0));
    bus(0, ADDR_SEL_FAULT, 32'h0);
    check("fault unfitted", 32'(q[4]), 1);
    option_module_fitted <= 1;
    repeat (4) @(posedge clk);
    rc(ADDR_OPTION, 32'h1, "option fitted");
    bus(0, ADDR_SEL_FAULT, 32'h0);
    check("fault fitted", 32'(q[4]), 0);
    $display("test selection done");
    // slower periods: a start edge and its release at the following tick lie one period apart
    wr(sa(1, 3, 1), 100);
    for (int p = 1; p < 3; p++) begin
      setsig(4, 500);
      wr(sa(1, 3, 0), cfgw(1, MODE_OVER, 4, 0) | (32'(p) << CFG_PERIOD_LSB));
      n = 0;
      while (stage_start[3] !== 1'b1 && n < 1000) begin
        @(posedge clk);
        n++;
      end
      setsig(4, 50);
      n = 0;
      while (stage_start[3] !== 1'b0 && n < 1000) begin
        @(posedge clk);
        n++;
      end
      check($sformatf("period code %0d", p), 32'(n), 32'((p == 1 ? PERIOD_20_MS : PERIOD_100_MS) * MSC));
    end
    $display("test periods done");
    results();
  end
endmodule
